// *** dprh_port_host.sv ***
// Purpose: Drives one port of an asynchronous dual-port memory with token latches.
// Assumes: Device pins are asynchronous to clk; busy and data in are synchronised.
// Notes:   Memory accesses that see busy are retried up to a limit.
`timescale 1ns/10ps

// Contract
// R1: Strobe held high throughout every read.
// R2: Token reads never use continuous-select form.
// R3: Memory: select, lane low; token: select high.
// R4: Strobe high whenever the address changes.
// R5: Device writes on select, lane, strobe overlap.
// R6: Host never drives data while device drives.
// R7: Select falls with strobe, outputs stay off.
// R8: Port select stays high for token write/read.
// R9: Device grants a contended token to one side.
// R10: Device asserts busy to exactly one port.
// R11: Busy makes the host retry the access.
module dprh_port_host #(
  parameter int BUSY_RETRY_MAX = 15
)(
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire dprh_pkg::dprh_req_t      req,
  output dprh_pkg::dprh_resp_t          resp,
  output dprh_pkg::dprh_pins_t          pins,
  input  wire logic [dprh_pkg::DATA_W-1:0] dq_in,
  input  wire logic                     busy_n
);
  import dprh_pkg::*;

  // The retry counter is four bits wide, so larger limits would wrap.
  if (BUSY_RETRY_MAX < 1 || BUSY_RETRY_MAX > 15)
  begin : g_bad_retry
    $error("BUSY_RETRY_MAX must lie in 1..15");
  end

  ////////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    dprh_state_t       st;
    logic [CNT_W-1:0]  cnt;
    logic [3:0]        retries;
    logic              retry;
    logic              write;
    logic              token;
    logic              upper;
    logic              lower;
    logic [DATA_W-1:0] wdata;
    logic              busy_m;
    logic              busy_s;
    logic [DATA_W-1:0] dq_m;
    logic [DATA_W-1:0] dq_s;
    dprh_pins_t        pins;
    dprh_resp_t        resp;
  } dprh_core_t;

  dprh_core_t r;
  dprh_core_t next_r;

  localparam dprh_pins_t PINS_IDLE = '{
    port_select_n:  1'h1,
    write_strobe_n: 1'h1,
    output_drive_n: 1'h1,
    upper_lane_n:   1'h1,
    lower_lane_n:   1'h1,
    token_select_n: 1'h1,
    addr:           '0,
    dq_out:         '0,
    dq_oe:          1'h0
  };

  localparam logic [CNT_W-1:0] SETUP_LAST   = CNT_W'(SETUP_CYC - 1);
  localparam logic [CNT_W-1:0] ACCESS_LAST  = CNT_W'(ACCESS_CYC - 1);
  localparam logic [CNT_W-1:0] PULSE_LAST   = CNT_W'(PULSE_CYC - 1);
  localparam logic [CNT_W-1:0] RECOVER_LAST = CNT_W'(RECOVER_CYC - 1);
  localparam logic [3:0]       RETRY_LIMIT  = 4'(BUSY_RETRY_MAX);

  ////////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    next_r = r;
    next_r.resp.done = 1'h0;
    next_r.resp.ready = 1'h0;
    // Two-stage synchronisers; only the second stage is used below.
    next_r.busy_m = busy_n;
    next_r.busy_s = r.busy_m;
    next_r.dq_m   = dq_in;
    next_r.dq_s   = r.dq_m;
    if (r.cnt != '0)
      next_r.cnt = r.cnt - CNT_W'(1);

    case (r.st)
      ST_IDLE:
      begin
        next_r.resp.ready = 1'h1;
        if (r.resp.ready && req.valid)
        begin
          next_r.resp.ready     = 1'h0;
          next_r.resp.busy_fail = 1'h0;
          next_r.write   = req.write;
          next_r.token   = req.token;
          next_r.upper   = req.upper;
          next_r.lower   = req.lower;
          next_r.wdata   = req.wdata;
          next_r.retries = '0;
          // Address moves only while the strobe is high and nothing is selected. [R4]
          next_r.pins      = PINS_IDLE;
          next_r.pins.addr = req.addr;
          next_r.cnt       = SETUP_LAST;
          next_r.st        = ST_SETUP;
        end
      end

      ST_SETUP:
      begin
        if (r.cnt == '0)
        begin
          // Token space: port select high, token select low, a lane low so the
          // latch is written; memory: port select low, lanes as asked. [R3] [R8]
          next_r.pins.port_select_n  = r.token;
          next_r.pins.token_select_n = !r.token;
          next_r.pins.upper_lane_n   = r.token ? 1'h1 : !r.upper;
          next_r.pins.lower_lane_n   = r.token ? 1'h0 : !r.lower;
          if (r.write)
          begin
            // Strobe falls in the same edge as the selects, so the device keeps
            // its outputs off and the data bus is ours for the whole pulse. [R7] [R6] [R5]
            next_r.pins.write_strobe_n = 1'h0;
            next_r.pins.output_drive_n = 1'h1;
            next_r.pins.dq_out         = r.token ? {{(DATA_W-1){1'h0}}, r.wdata[0]} : r.wdata;
            next_r.pins.dq_oe          = 1'h1;
            next_r.cnt                 = PULSE_LAST;
            next_r.st                  = ST_WRITE;
          end
          else
          begin
            // Each read is framed by a fresh select with the strobe high, so a
            // token read never relies on a continuously selected port. [R1] [R2]
            next_r.pins.write_strobe_n = 1'h1;
            next_r.pins.output_drive_n = 1'h0;
            next_r.pins.dq_oe          = 1'h0;
            next_r.cnt                 = ACCESS_LAST;
            next_r.st                  = ST_READ;
          end
        end
      end

      ST_READ:
      begin
        if (r.cnt == '0)
        begin
          next_r.pins = PINS_IDLE;
          next_r.pins.addr = r.pins.addr;
          // Busy matters only for memory space; tokens arbitrate on their own.
          if (!r.token && !r.busy_s)
            next_r.retry = 1'h1; // [R11]
          else
          begin
            next_r.retry = 1'h0;
            next_r.resp.rdata = r.token ? {{(DATA_W-1){1'h0}}, r.dq_s[0]} : r.dq_s;
          end
          next_r.cnt = RECOVER_LAST;
          next_r.st  = ST_RECOVER;
        end
      end

      ST_WRITE:
      begin
        if (r.cnt == '0)
        begin
          // Strobe and selects rise together; data is held one more cycle.
          next_r.pins.write_strobe_n = 1'h1;
          next_r.pins.port_select_n  = 1'h1;
          next_r.pins.token_select_n = 1'h1;
          next_r.pins.upper_lane_n   = 1'h1;
          next_r.pins.lower_lane_n   = 1'h1;
          // A write that met busy may have been inhibited, so it is repeated. [R11]
          next_r.retry = !r.token && !r.busy_s;
          next_r.st    = ST_HOLD;
        end
      end

      ST_HOLD:
      begin
        next_r.pins.dq_oe = 1'h0; // [R6]
        next_r.cnt = RECOVER_LAST;
        next_r.st  = ST_RECOVER;
      end

      ST_RECOVER:
      begin
        // The gap covers output turn-off and the token update and write-to-read
        // times, so a token read-back after a write sees the new state. [R8] [R6]
        if (r.cnt == '0)
        begin
          if (r.retry && r.retries != RETRY_LIMIT)
          begin
            next_r.retries = r.retries + 4'h1;
            next_r.cnt     = SETUP_LAST;
            next_r.st      = ST_SETUP; // [R11]
          end
          else
          begin
            next_r.resp.busy_fail = r.retry;
            next_r.resp.done      = 1'h1;
            next_r.retry          = 1'h0;
            next_r.st             = ST_IDLE;
          end
        end
      end

      default:
      begin
        next_r.pins = PINS_IDLE;
        next_r.st   = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      r         <= '0;
      r.st      <= ST_IDLE;
      r.busy_m  <= 1'h1;
      r.busy_s  <= 1'h1;
      r.pins    <= PINS_IDLE;
    end
    else
      r <= next_r;
  end

  assign resp = r.resp;
  assign pins = r.pins;

endmodule : dprh_port_host

// *** dprh_pkg.sv ***
// Purpose: Shared constants and carrier types for the dual-port memory port host.
// Assumes: 100 MHz clock, slowest speed grade timing figures, 8K x 16 port.
// Notes:   Cycle counts are derived from the nanosecond figures below.
package dprh_pkg;

  localparam int CLK_PERIOD_NS = 10;

  localparam int ADDR_W = 13;
  localparam int DATA_W = 16;

  // Timing figures in ns for the slowest grade.
  localparam int T_ACCESS_NS       = 55;
  localparam int T_WRITE_PULSE_NS  = 35;
  localparam int T_OUT_HIGHZ_NS    = 25;
  localparam int T_TOKEN_PULSE_NS  = 20;
  localparam int T_TOKEN_WR_RD_NS  = 15;
  localparam int T_TOKEN_CONTENTION_WINDOW_NS = 15;
  localparam int T_PRIORITY_SETUP_WINDOW_NS   = 5;

  // Least times round up to whole cycles, never below one.
  function automatic int dprh_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : dprh_cyc

  localparam int SYNC_CYC    = 2;
  localparam int SETUP_CYC   = dprh_cyc(T_PRIORITY_SETUP_WINDOW_NS);
  localparam int ACCESS_CYC  = dprh_cyc(T_ACCESS_NS) + SYNC_CYC;
  localparam int PULSE_CYC   = dprh_cyc(T_WRITE_PULSE_NS) + SYNC_CYC;
  localparam int REC_HZ_CYC  = dprh_cyc(T_OUT_HIGHZ_NS);
  localparam int REC_TOK_CYC = (dprh_cyc(T_TOKEN_PULSE_NS) > dprh_cyc(T_TOKEN_WR_RD_NS))
                             ? dprh_cyc(T_TOKEN_PULSE_NS) : dprh_cyc(T_TOKEN_WR_RD_NS);
  localparam int RECOVER_CYC = (REC_HZ_CYC > REC_TOK_CYC) ? REC_HZ_CYC : REC_TOK_CYC;
  localparam int CNT_W       = 4;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_READ,
    ST_WRITE,
    ST_HOLD,
    ST_RECOVER
  } dprh_state_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic              token;
    logic              upper;
    logic              lower;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dprh_req_t;

  typedef struct packed {
    logic              ready;
    logic              done;
    logic              busy_fail;
    logic [DATA_W-1:0] rdata;
  } dprh_resp_t;

  typedef struct packed {
    logic              port_select_n;
    logic              write_strobe_n;
    logic              output_drive_n;
    logic              upper_lane_n;
    logic              lower_lane_n;
    logic              token_select_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe;
  } dprh_pins_t;

endpackage : dprh_pkg

// *** dprh_port_host_asserts.sv ***
// Purpose: Pin protocol checks for one memory port host.
// Assumes: Bound to dprh_port_host; sees only its ports.
// Notes:   Device-side behaviour is judged by the bench.
`timescale 1ns/10ps
module dprh_port_host_asserts import dprh_pkg::*; #(
  parameter int BUSY_RETRY_MAX = 15
)(
  input wire logic                      clk,
  input wire logic                      reset,
  input wire dprh_pkg::dprh_req_t       req,
  input wire dprh_pkg::dprh_resp_t      resp,
  input wire dprh_pkg::dprh_pins_t      pins,
  input wire logic [dprh_pkg::DATA_W-1:0] dq_in,
  input wire logic                      busy_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_wr_open;
    $fell(pins.write_strobe_n);
  endsequence
  sequence s_pulse;
    !pins.write_strobe_n [*6] ##1 pins.write_strobe_n;
  endsequence
  read_strobe_a: assert property (!pins.output_drive_n |-> pins.write_strobe_n)
    else $error("strobe low while outputs driven");
  addr_move_a: assert property (
    !$stable(pins.addr) |-> pins.write_strobe_n && $past(pins.write_strobe_n))
    else $error("address moved during write");
  mem_select_a: assert property (
    !pins.port_select_n |->
      pins.token_select_n && !(pins.upper_lane_n && pins.lower_lane_n))
    else $error("bad memory select");
  token_select_a: assert property (
    !pins.token_select_n |-> pins.port_select_n && !pins.lower_lane_n)
    else $error("bad token select");
  drive_clash_a: assert property (pins.dq_oe |-> pins.output_drive_n)
    else $error("data fight on pins");
  write_open_a: assert property (
    s_wr_open |-> pins.dq_oe && !(pins.port_select_n && pins.token_select_n))
    else $error("write without select or data");
  pulse_len_a: assert property (s_wr_open |-> s_pulse)
    else $error("write pulse length wrong");
  idle_off_a: assert property (resp.done |-> pins.port_select_n && pins.token_select_n)
    else $error("select left on after transfer");
  done_pulse_a: assert property (resp.done |-> !resp.ready ##1 (resp.ready && !resp.done))
    else $error("done or ready framing wrong");
endmodule : dprh_port_host_asserts
bind dprh_port_host dprh_port_host_asserts #(.BUSY_RETRY_MAX(BUSY_RETRY_MAX)) u_chk (.clk(clk),
  .reset(reset), .req(req), .resp(resp), .pins(pins), .dq_in(dq_in), .busy_n(busy_n));

// *** dprh_dev_model.sv ***
// Purpose: Behavioural model of the dual-port memory seen from one port.
// Assumes: Sampled on clk; busy and the far port are bench controls.
// Notes:   Released data pins show a changing pattern, never the last word.
`timescale 1ns/10ps
module dprh_dev_model import dprh_pkg::*; (
  input  wire logic                         clk,
  input  wire dprh_pkg::dprh_pins_t         pins,
  input  wire logic                         busy_on,
  input  wire logic                         other_holds,
  output logic [dprh_pkg::DATA_W-1:0]       dq_in,
  output logic                              busy_n
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] last = '0;
  logic              tok = 1'b1;
  logic              ram_sel;
  logic              tok_sel;
  logic              drive;
  logic              wr;
  assign ram_sel = !pins.port_select_n && pins.token_select_n;
  assign tok_sel = pins.port_select_n && !pins.token_select_n;
  assign wr = !pins.write_strobe_n;
  // Outputs stay off while the strobe is low, whatever order the selects took.
  assign drive = (ram_sel || tok_sel) && !pins.output_drive_n && !wr;
  assign busy_n = !(busy_on && ram_sel);
  assign dq_in = !drive ? ~last : tok_sel ? {{(DATA_W-1){1'b0}}, tok} : mem[pins.addr];
  always @(posedge clk)
  begin
    last <= dq_in;
    if (ram_sel && wr && !pins.upper_lane_n) mem[pins.addr][15:8] <= pins.dq_out[15:8];
    if (ram_sel && wr && !pins.lower_lane_n) mem[pins.addr][7:0] <= pins.dq_out[7:0];
    // A far side holding the latch wins any request.
    if (tok_sel && wr && !pins.lower_lane_n) tok <= pins.dq_out[0] || other_holds;
  end
endmodule : dprh_dev_model

// *** dual_port_ram_port_access_tb.sv ***
// Purpose: Self-checking bench for the memory port host.
// Assumes: One retry allowed, so busy cases stay short.
// Notes:   Latencies are built from the package cycle counts.
`timescale 1ns/10ps
module dual_port_ram_port_access_tb;
  import dprh_pkg::*;
  logic              clk = 1'b0;
  logic              reset = 1'b1;
  logic              busy_on = 1'b0;
  logic              other_holds = 1'b0;
  dprh_req_t         req = '0;
  dprh_resp_t        resp;
  dprh_pins_t        pins;
  logic [DATA_W-1:0] dq_in;
  logic              busy_n;
  int                n_errors = 0;
  int                check_count = 0;
  // Edges from the taking edge to done; a write adds one data hold cycle.
  localparam int     RD_LAT = SETUP_CYC + ACCESS_CYC + RECOVER_CYC;
  localparam int     WR_LAT = SETUP_CYC + PULSE_CYC + 1 + RECOVER_CYC;
  dprh_port_host #(.BUSY_RETRY_MAX(1)) dut (.clk(clk), .reset(reset), .req(req), .resp(resp),
    .pins(pins), .dq_in(dq_in), .busy_n(busy_n));
  dprh_dev_model u_dev (.clk(clk), .pins(pins), .busy_on(busy_on), .other_holds(other_holds),
    .dq_in(dq_in), .busy_n(busy_n));
  initial forever #5 clk = ~clk;
  //////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic xfer(input logic w, t, up, lo, input logic [12:0] a, input logic [15:0] d,
                      input int lat);
    int n;
    n = 0;
    while (resp.ready !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      #1 n = n + 1;
    end
    if (n >= 50)
    begin
      chk(n, 0);
      wrap_up();
    end
    @(posedge clk);
    req <= '{1'b1, w, t, up, lo, a, d};
    @(posedge clk);
    req.valid <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk);
      #1 n = n + 1;
    end
    while (resp.done !== 1'b1 && n < 200);
    chk(n, lat);
    if (n >= 200) wrap_up();
  endtask : xfer
  //////////////////////////////////////////////////
  task automatic t_reset;
    #1 chk(resp, 0);
    @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1 chk({pins[35:30], pins.addr, pins.dq_oe}, {6'h3f, 13'h0, 1'b0});
  endtask : t_reset
  task automatic t_ram;
    xfer(1, 0, 1, 1, 13'h1fff, 16'ha5c3, WR_LAT);
    xfer(1, 0, 1, 0, 13'h1fff, 16'h7e00, WR_LAT);
    xfer(0, 0, 1, 1, 13'h1fff, 16'h0, RD_LAT);
    chk(resp.rdata, 16'h7ec3);
    xfer(1, 0, 0, 1, 13'h0000, 16'h0f1e, WR_LAT);
    xfer(0, 0, 0, 1, 13'h0000, 16'h0, RD_LAT);
    chk(resp.rdata[7:0], 8'h1e);
  endtask : t_ram
  task automatic t_token;
    xfer(1, 1, 0, 1, 13'h0003, 16'h0, WR_LAT);
    xfer(0, 1, 0, 1, 13'h0003, 16'h0, RD_LAT);
    chk(resp.rdata, 16'h0);
    @(posedge clk);
    other_holds <= 1'b1;
    xfer(1, 1, 0, 1, 13'h0003, 16'h1, WR_LAT);
    xfer(1, 1, 0, 1, 13'h0003, 16'h0, WR_LAT);
    xfer(0, 1, 0, 1, 13'h0003, 16'h0, RD_LAT);
    chk(resp.rdata, 16'h1);
    other_holds <= 1'b0;
  endtask : t_token
  task automatic t_busy;
    @(posedge clk);
    busy_on <= 1'b1;
    // One retry is allowed, so a busy transfer runs its full length twice.
    xfer(1, 0, 1, 1, 13'h0002, 16'h1234, 2 * WR_LAT);
    chk(resp.busy_fail, 1'b1);
    xfer(0, 0, 1, 1, 13'h1fff, 16'h0, 2 * RD_LAT);
    chk(resp.busy_fail, 1'b1);
    fork
      xfer(0, 0, 1, 1, 13'h1fff, 16'h0, 2 * RD_LAT);
      begin
        repeat (12) @(posedge clk);
        busy_on <= 1'b0;
      end
    join
    chk({resp.busy_fail, resp.rdata}, {1'b0, 16'h7ec3});
  endtask : t_busy
  //////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge clk);
    t_reset();
    t_ram();
    t_token();
    t_busy();
    wrap_up();
  end
endmodule : dual_port_ram_port_access_tb
